// ---- hw/rcio_receiver_io.sv ----
// Overview of operation
// - Overload, loop, tuning requests drive priority interrupts
// - Loop monitors and supply comparators on separate ports
// - Stop and local keys debounced, latched, readable
// - Hall pulses give count and direction to counter
// - Tuning counter readable; software polls it
// - First pulse after readout fires delayed one-shot
// - Frequency held on outputs for display, synthesizers
// - Recorder X code 10 bits from two ports
// - Recorder Y code 8 bits from own port
// - Pen lift, format advance share X port
// - Divider makes 250 kHz converter clock
// - Start and stop resynchronised to converter clock
// - Software drives converter lines, reads result
// - Calibration reached flag readable as status
// - Switch enable high exactly when function true
// - Direct and meter inputs mutually exclusive
// - Centre status low inside window, else high
// - Positive or negative peak path, never both
// - Discharge bit closes both discharge switches
//
// Local design decisions: the plain strobed port and the register offsets.
module rcio_receiver_io #(
  parameter int TUNE_W = 8,
  parameter int TUNE_DELAY = rcio_pkg::TUNE_DELAY_CYC,
  parameter int DEBOUNCE = rcio_pkg::DEBOUNCE_CYC,
  parameter int ADC_W = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic mixerOverload,
  input wire logic [3:0] loopMonitor,
  input wire logic [7:0] supplyCompare,
  input wire logic stopKey,
  input wire logic localKey,
  input wire logic hallA,
  input wire logic hallB,
  input wire logic calReached,
  input wire logic centreInWindow,
  input wire logic [ADC_W-1:0] adcResult,
  output logic restart_interrupt_level_low,
  output logic restart_interrupt_level_mid,
  output logic restart_interrupt_level_upper,
  output logic restart_interrupt_level_high,
  output logic [23:0] freqOut,
  output logic [9:0] recXCode,
  output logic [7:0] recYCode,
  output logic recPenLift,
  output logic recFormatAdvance,
  output logic adcClock,
  output logic adcStartStop,
  output logic adcSampleHold,
  output logic centreStatus,
  output rcio_pkg::rcio_sw_t switchEnable
);
  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  // Width must match the packed pin list exactly, or the first pin falls off
  localparam int NSYNC = 19;
  logic [NSYNC-1:0] syncRaw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign syncRaw = {mixerOverload, loopMonitor, supplyCompare, stopKey, localKey,
                    hallA, hallB, calReached, centreInWindow};

  // Two stages for every pin; stage one feeds only stage two
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= syncRaw;
      sync2_q <= sync1_q;
    end
  end

  logic sOverload;
  logic [3:0] sLoop;
  logic [7:0] sSupply;
  logic sStop;
  logic sLocal;
  logic sHallA;
  logic sHallB;
  logic sCal;
  logic sCentre;
  assign {sOverload, sLoop, sSupply, sStop, sLocal, sHallA, sHallB, sCal, sCentre} = sync2_q;

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  wire wrFreqLo = wrStrobe && (addr == rcio_pkg::ADDR_FREQ_LO);
  wire wrFreqMid = wrStrobe && (addr == rcio_pkg::ADDR_FREQ_MID);
  wire wrFreqHi = wrStrobe && (addr == rcio_pkg::ADDR_FREQ_HI);
  wire wrRecXLo = wrStrobe && (addr == rcio_pkg::ADDR_REC_X_LO);
  wire wrRecXHi = wrStrobe && (addr == rcio_pkg::ADDR_REC_X_HI);
  wire wrRecY = wrStrobe && (addr == rcio_pkg::ADDR_REC_Y);
  wire wrModeLo = wrStrobe && (addr == rcio_pkg::ADDR_MODE);
  wire wrModeHi = wrStrobe && (addr == (rcio_pkg::ADDR_MODE + 8'h01));
  wire wrAdcCtrl = wrStrobe && (addr == rcio_pkg::ADDR_ADC_CTRL);
  wire rdTune = rdStrobe && (addr == rcio_pkg::ADDR_TUNE_CNT);

  // ********************************************************************
  // Key debounce and latch
  // ********************************************************************
  localparam int DBW = $clog2(DEBOUNCE + 1);
  logic [1:0] keyRaw;
  logic [1:0] keyLatch_q;
  assign keyRaw = {sStop, sLocal};

  genvar k;
  generate
    for (k = 0; k < 2; k++)
    begin : gKey
      logic [DBW-1:0] dbCnt_q;
      wire differs = keyRaw[k] != keyLatch_q[k];
      wire settled = dbCnt_q == DBW'(DEBOUNCE - 1);
      // Latch only after the level has held steady for the whole window
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          dbCnt_q <= '0;
          keyLatch_q[k] <= 1'b0;
        end
        else if (!differs)
          dbCnt_q <= '0;
        else if (settled)
        begin
          dbCnt_q <= '0;
          keyLatch_q[k] <= keyRaw[k];
        end
        else
          dbCnt_q <= dbCnt_q + DBW'(1);
      end
    end
  endgenerate

  // ********************************************************************
  // Tuning encoder: count pulse, direction, counter
  // ********************************************************************
  logic hallAPrev_q;
  logic [TUNE_W-1:0] tuneCnt_q;
  // Count on rising A; B level at that edge gives the direction
  wire countPulse = sHallA && !hallAPrev_q;
  wire countUp = sHallB;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hallAPrev_q <= 1'b0;
      tuneCnt_q <= '0;
    end
    else
    begin
      hallAPrev_q <= sHallA;
      if (countPulse)
        tuneCnt_q <= countUp ? tuneCnt_q + TUNE_W'(1) : tuneCnt_q - TUNE_W'(1);
    end
  end

  // ********************************************************************
  // Delayed tuning request
  // ********************************************************************
  localparam int TDW = $clog2(TUNE_DELAY + 1);
  typedef enum logic [1:0] {TUNE_ARMED, TUNE_TIMING, TUNE_DONE} rcio_tune_t;
  rcio_tune_t tuneState_q;
  rcio_tune_t tuneState_d;
  logic [TDW-1:0] tuneTmr_q;
  wire tuneExpired = tuneTmr_q == TDW'(TUNE_DELAY - 1);

  // A readout always wins, so the next pulse is seen as a first one again
  always_comb
  begin
    tuneState_d = tuneState_q;
    unique case (tuneState_q)
      TUNE_ARMED: if (countPulse) tuneState_d = TUNE_TIMING;
      TUNE_TIMING: if (tuneExpired) tuneState_d = TUNE_DONE;
      TUNE_DONE: tuneState_d = TUNE_DONE;
    endcase
    if (rdTune)
      tuneState_d = TUNE_ARMED;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tuneState_q <= TUNE_ARMED;
      tuneTmr_q <= '0;
    end
    else
    begin
      tuneState_q <= tuneState_d;
      tuneTmr_q <= (tuneState_q == TUNE_TIMING) ? tuneTmr_q + TDW'(1) : '0;
    end
  end

  // ********************************************************************
  // Interrupt lines
  // ********************************************************************
  // Registered so each line comes straight from a flop
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      restart_interrupt_level_low <= 1'b0;
      restart_interrupt_level_mid <= 1'b0;
      restart_interrupt_level_upper <= 1'b0;
      restart_interrupt_level_high <= 1'b0;
    end
    else
    begin
      restart_interrupt_level_low <= sOverload;
      // Oscillator loops on the mid line, synthesizer loops on the upper one;
      // all four monitors still read back on the loop status port
      restart_interrupt_level_mid <= |sLoop[1:0];
      restart_interrupt_level_upper <= |sLoop[3:2];
      restart_interrupt_level_high <= tuneState_d == TUNE_DONE;
    end
  end

  // ********************************************************************
  // Output ports
  // ********************************************************************
  logic [2:0] modeHiBits_q;
  logic [7:0] modeLo_q;
  logic [2:0] adcCtrl_q;

  // Software-written ports; each holds until rewritten
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      freqOut <= '0;
      recXCode <= '0;
      recYCode <= '0;
      recPenLift <= 1'b0;
      recFormatAdvance <= 1'b0;
      modeLo_q <= '0;
      modeHiBits_q <= '0;
      adcCtrl_q <= '0;
    end
    else
    begin
      if (wrFreqLo) freqOut[7:0] <= wrData;
      if (wrFreqMid) freqOut[15:8] <= wrData;
      if (wrFreqHi) freqOut[23:16] <= wrData;
      if (wrRecXLo) recXCode[7:0] <= wrData;
      if (wrRecXHi)
      begin
        recXCode[9:8] <= wrData[rcio_pkg::REC_X_HI_CODE_W-1:0];
        recPenLift <= wrData[rcio_pkg::REC_PEN_LIFT_BIT];
        recFormatAdvance <= wrData[rcio_pkg::REC_FORMAT_BIT];
      end
      if (wrRecY) recYCode <= wrData;
      if (wrModeLo) modeLo_q <= wrData;
      if (wrModeHi) modeHiBits_q <= wrData[2:0];
      if (wrAdcCtrl) adcCtrl_q <= wrData[2:0];
    end
  end

  // ********************************************************************
  // Converter clock and start/stop sync
  // ********************************************************************
  localparam int ADW = $clog2(rcio_pkg::ADC_HALF_DIV);
  logic [ADW-1:0] adcDiv_q;
  logic runReq_q;
  wire adcHalf = adcDiv_q == ADW'(rcio_pkg::ADC_HALF_DIV - 1);
  wire adcRise = adcHalf && !adcClock;

  // Start sets, stop clears; the pin moves only on a converter clock rise
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      adcDiv_q <= '0;
      adcClock <= 1'b0;
      runReq_q <= 1'b0;
      adcStartStop <= 1'b0;
      adcSampleHold <= 1'b0;
    end
    else
    begin
      adcDiv_q <= adcHalf ? '0 : adcDiv_q + ADW'(1);
      if (adcHalf) adcClock <= !adcClock;
      if (wrAdcCtrl && wrData[rcio_pkg::ADC_START_BIT]) runReq_q <= 1'b1;
      else if (wrAdcCtrl && wrData[rcio_pkg::ADC_STOP_BIT]) runReq_q <= 1'b0;
      if (adcRise) adcStartStop <= runReq_q;
      adcSampleHold <= adcCtrl_q[rcio_pkg::ADC_SH_BIT];
    end
  end

  // ********************************************************************
  // Analog switch decode
  // ********************************************************************
  rcio_pkg::rcio_mode_t mode;
  rcio_pkg::rcio_sw_t swNext;
  // Upper port: bit 0 positive, bit 1 negative, bit 2 discharge command;
  // one fixed wire per mode bit, so every field can be set by software
  assign mode = {modeHiBits_q, modeLo_q};
  wire cispr = mode.cispr1 || mode.cispr3;
  wire logAny = mode.log40 || mode.log60;
  wire wideGain = cispr || mode.peak3s || logAny;
  assign swNext.directIn = !cispr;
  assign swNext.meterSimIn = cispr;
  assign swNext.gainSel = wideGain;
  assign swNext.gainUnity = !wideGain;
  assign swNext.gainStage = wideGain;
  assign swNext.logPath = !logAny;
  assign swNext.linPath = logAny;
  assign swNext.offsetPath = !mode.deviation;
  assign swNext.notModPath = !mode.modDepth;
  assign swNext.modPath = mode.modDepth;
  assign swNext.dischargeA = mode.discharge;
  assign swNext.dischargeB = mode.discharge;
  assign swNext.levelPath = !mode.levelMeas;
  // Positive wins if software sets both, so the paths never overlap
  assign swNext.posPeak = mode.deviation && mode.devPos;
  assign swNext.negPeak = mode.deviation && mode.devNeg && !mode.devPos;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      switchEnable <= '0;
      centreStatus <= 1'b1;
    end
    else
    begin
      switchEnable <= swNext;
      centreStatus <= !sCentre;
    end
  end

  // ********************************************************************
  // Read mux
  // ********************************************************************
  logic [7:0] rdNext;
  always_comb
  begin
    unique case (addr)
      rcio_pkg::ADDR_LOOP_STAT: rdNext = {4'h0, sLoop};
      rcio_pkg::ADDR_PSU_STAT: rdNext = sSupply;
      rcio_pkg::ADDR_KEY_STAT: rdNext = {6'h00, keyLatch_q};
      rcio_pkg::ADDR_TUNE_CNT: rdNext = 8'(tuneCnt_q);
      rcio_pkg::ADDR_ADC_DATA: rdNext = adcResult[7:0];
      rcio_pkg::ADDR_ADC_DATA + 8'h01: rdNext = 8'({adcStartStop, 5'h00, adcResult[9:8]});
      rcio_pkg::ADDR_ANA_STAT: rdNext = {6'h00, centreStatus, sCal};
      default: rdNext = 8'h00;
    endcase
  end

  // Data valid in the cycle after the strobe only
  always_ff @(posedge clock)
  begin
    if (rst)
      rdData <= 8'h00;
    else
      rdData <= rdStrobe ? rdNext : 8'h00;
  end
endmodule

// ---- hw/rcio_pkg.sv ----
package rcio_pkg;
  // ********************************************************************
  // Register offsets (byte addresses on the plain port)
  // ********************************************************************
  localparam logic [7:0] ADDR_LOOP_STAT = 8'h00;
  localparam logic [7:0] ADDR_PSU_STAT = 8'h04;
  localparam logic [7:0] ADDR_KEY_STAT = 8'h08;
  localparam logic [7:0] ADDR_TUNE_CNT = 8'h0c;
  localparam logic [7:0] ADDR_FREQ_LO = 8'h10;
  localparam logic [7:0] ADDR_FREQ_MID = 8'h14;
  localparam logic [7:0] ADDR_FREQ_HI = 8'h18;
  localparam logic [7:0] ADDR_REC_X_LO = 8'h1c;
  localparam logic [7:0] ADDR_REC_X_HI = 8'h20;
  localparam logic [7:0] ADDR_REC_Y = 8'h24;
  localparam logic [7:0] ADDR_MODE = 8'h28;
  localparam logic [7:0] ADDR_ADC_CTRL = 8'h2c;
  localparam logic [7:0] ADDR_ADC_DATA = 8'h30;
  localparam logic [7:0] ADDR_ANA_STAT = 8'h34;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int REC_X_HI_CODE_W = 2;
  localparam int REC_PEN_LIFT_BIT = 6;
  localparam int REC_FORMAT_BIT = 7;
  localparam int ADC_START_BIT = 0;
  localparam int ADC_STOP_BIT = 1;
  localparam int ADC_SH_BIT = 2;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLOCK_HZ = 100000000;
  localparam int ADC_CLK_HZ = 250000;
  localparam int ADC_HALF_DIV = CLOCK_HZ / ADC_CLK_HZ / 2;
  localparam int TUNE_DELAY_MS = 50;
  localparam int TUNE_DELAY_CYC = CLOCK_HZ / 1000 * TUNE_DELAY_MS;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYC = CLOCK_HZ / 1000000 * DEBOUNCE_US;

  // Mode bits written by software
  typedef struct packed {
    logic discharge;
    logic devNeg;
    logic devPos;
    logic deviation;
    logic modDepth;
    logic levelMeas;
    logic log60;
    logic log40;
    logic peak3s;
    logic cispr3;
    logic cispr1;
  } rcio_mode_t;

  // Analog switch enables
  typedef struct packed {
    logic directIn;
    logic meterSimIn;
    logic gainSel;
    logic gainUnity;
    logic gainStage;
    logic logPath;
    logic linPath;
    logic offsetPath;
    logic notModPath;
    logic modPath;
    logic dischargeA;
    logic dischargeB;
    logic levelPath;
    logic posPeak;
    logic negPeak;
  } rcio_sw_t;
endpackage

// ---- sim/rcio_receiver_io_monitor.sv ----
// ********************
// Port relation checker
// ********************
module rcio_receiver_io_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic mixerOverload,
  input wire logic centreInWindow,
  input wire logic restart_interrupt_level_low,
  input wire logic restart_interrupt_level_high,
  input wire logic [9:0] recXCode,
  input wire logic [7:0] recYCode,
  input wire logic adcClock,
  input wire logic adcStartStop,
  input wire logic centreStatus,
  input wire rcio_pkg::rcio_sw_t switchEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic prevClk_q;
  logic seen_q;
  logic [8:0] halfCnt_q;
  // Half period counter; first edge after reset is skipped, its phase is free
  always_ff @(posedge clock)
  begin
    prevClk_q <= adcClock;
    if (rst)
      seen_q <= 1'b0;
    else if (adcClock != prevClk_q)
      seen_q <= 1'b1;
    halfCnt_q <= (adcClock != prevClk_q) ? 9'h001 : halfCnt_q + 9'h001;
  end
  property p_rd_idle; !rdStrobe |=> rdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_rec_y; wrStrobe && addr == rcio_pkg::ADDR_REC_Y |=> recYCode == $past(wrData); endproperty
  a_rec_y: assert property (p_rec_y) else $error("level code not taken");
  property p_rec_x; wrStrobe && addr == rcio_pkg::ADDR_REC_X_LO |=> recXCode[7:0] == $past(wrData);
  endproperty
  a_rec_x: assert property (p_rec_x) else $error("frequency code low byte not taken");
  property p_in_excl; wrStrobe && addr == rcio_pkg::ADDR_MODE |=>
    switchEnable.directIn != switchEnable.meterSimIn; endproperty
  a_in_excl: assert property (p_in_excl) else $error("input switches not exclusive");
  property p_peak_excl; !(switchEnable.posPeak && switchEnable.negPeak); endproperty
  a_peak_excl: assert property (p_peak_excl) else $error("both peak paths on");
  property p_dis_pair; switchEnable.dischargeA == switchEnable.dischargeB; endproperty
  a_dis_pair: assert property (p_dis_pair) else $error("discharge switches differ");
  property p_adc_half; seen_q && adcClock != prevClk_q |-> halfCnt_q == rcio_pkg::ADC_HALF_DIV;
  endproperty
  a_adc_half: assert property (p_adc_half) else $error("converter clock half period wrong");
  property p_run_sync; $changed(adcStartStop) |-> $rose(adcClock); endproperty
  a_run_sync: assert property (p_run_sync) else $error("run level off converter clock");
  property p_tune_clr; rdStrobe && addr == rcio_pkg::ADDR_TUNE_CNT |=> !restart_interrupt_level_high;
  endproperty
  a_tune_clr: assert property (p_tune_clr) else $error("tuning request kept after read");
  property p_ovl; mixerOverload [*5] |-> restart_interrupt_level_low; endproperty
  a_ovl: assert property (p_ovl) else $error("overload interrupt missing");
  property p_centre; centreInWindow [*5] |-> !centreStatus; endproperty
  a_centre: assert property (p_centre) else $error("centre status not low");
  c_tune: cover property ($rose(restart_interrupt_level_high));
  c_run: cover property ($rose(adcStartStop));
  c_centre: cover property ($fell(centreStatus));
endmodule

// ---- sim/rcio_knob_model.sv ----
// ********************
// Tuning knob sensor pair
// ********************
module rcio_knob_model (
  input wire logic clock,
  input wire logic stepReq,
  input wire logic stepUp,
  output logic hallA,
  output logic hallB
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] phase_q = 4'h0;
  logic dir_q = 1'b0;
  // Direction settles before the count edge so the pair reads cleanly
  always_ff @(posedge clock)
  begin
    if (stepReq)
    begin
      phase_q <= 4'h1;
      dir_q <= stepUp;
    end
    else if (phase_q != 4'h0)
      phase_q <= phase_q + 4'h1;
  end
  // Four cycle pulse, longer than the two stage synchroniser needs
  assign hallA = (phase_q >= 4'h3) && (phase_q <= 4'h6);
  assign hallB = dir_q;
endmodule

// ---- sim/tb_top.sv ----
// ********************
// Bench top
// ********************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic mixerOverload = 1'b0;
  logic [3:0] loopMonitor = 4'h0;
  logic [7:0] supplyCompare = 8'h00;
  logic stopKey = 1'b0;
  logic localKey = 1'b0;
  logic centreInWindow = 1'b0;
  logic calReached = 1'b0;
  logic [9:0] adcResult = 10'h2a5;
  logic stepReq = 1'b0;
  logic stepUp = 1'b1;
  logic hallA, hallB, irqLow, irqMid, irqUpper, irqHigh, penLift, formatAdv;
  logic adcClock, adcStartStop, adcSampleHold, centreStatus;
  logic [7:0] rdData, recYCode;
  logic [23:0] freqOut;
  logic [9:0] recXCode;
  rcio_pkg::rcio_sw_t sw;
  int errors = 0;
  int samples_checked = 0;
  int n;
  // Short counts keep the run brief
  rcio_receiver_io #(.TUNE_W(8), .TUNE_DELAY(20), .DEBOUNCE(4), .ADC_W(10)) i_rcio_receiver_io (
    .clock(clock), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .mixerOverload(mixerOverload),
    .loopMonitor(loopMonitor), .supplyCompare(supplyCompare), .stopKey(stopKey),
    .localKey(localKey), .hallA(hallA), .hallB(hallB), .calReached(calReached),
    .centreInWindow(centreInWindow), .adcResult(adcResult),
    .restart_interrupt_level_low(irqLow), .restart_interrupt_level_mid(irqMid),
    .restart_interrupt_level_upper(irqUpper), .restart_interrupt_level_high(irqHigh),
    .freqOut(freqOut), .recXCode(recXCode), .recYCode(recYCode), .recPenLift(penLift),
    .recFormatAdvance(formatAdv), .adcClock(adcClock), .adcStartStop(adcStartStop),
    .adcSampleHold(adcSampleHold), .centreStatus(centreStatus), .switchEnable(sw));
  rcio_knob_model i_rcio_knob_model (.clock(clock), .stepReq(stepReq), .stepUp(stepUp),
    .hallA(hallA), .hallB(hallB));
  // Clock and hang guard
  always #5 clock = ~clock;
  initial
  begin
    #100us;
    errors++;
    summarize();
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
  endtask
  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1;
    chk({16'h0000, rdData}, {16'h0000, exp});
  endtask
  task automatic step(input logic up);
    @(posedge clock);
    stepUp <= up;
    stepReq <= 1'b1;
    @(posedge clock);
    stepReq <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    settle(1);
    chk({freqOut[22:0], centreStatus}, 24'h000001);
    $display("test reset done");
    wr(rcio_pkg::ADDR_FREQ_LO, 8'h56);
    wr(rcio_pkg::ADDR_FREQ_MID, 8'h34);
    wr(rcio_pkg::ADDR_FREQ_HI, 8'h12);
    wr(rcio_pkg::ADDR_REC_X_LO, 8'ha5);
    wr(rcio_pkg::ADDR_REC_X_HI, 8'hc3);
    wr(rcio_pkg::ADDR_REC_Y, 8'h5a);
    settle(1);
    chk(freqOut, 24'h123456);
    chk({12'h000, penLift, formatAdv, recXCode}, 24'h000fa5);
    chk({16'h0000, recYCode}, 24'h00005a);
    wr(rcio_pkg::ADDR_REC_X_HI, 8'h41);
    settle(1);
    chk({12'h000, penLift, formatAdv, recXCode}, 24'h0009a5);
    rd(8'h3c, 8'h00);
    wr(8'h3c, 8'hff);
    settle(1);
    chk(freqOut, 24'h123456);
    $display("test outputs done");
    @(posedge clock);
    loopMonitor <= 4'h5;
    supplyCompare <= 8'ha3;
    mixerOverload <= 1'b1;
    settle(5);
    chk({21'h000000, irqLow, irqMid, irqUpper}, 24'h000007);
    rd(rcio_pkg::ADDR_LOOP_STAT, 8'h05);
    rd(rcio_pkg::ADDR_PSU_STAT, 8'ha3);
    @(posedge clock);
    loopMonitor <= 4'h0;
    mixerOverload <= 1'b0;
    settle(5);
    chk({21'h000000, irqLow, irqMid, irqUpper}, 24'h000000);
    $display("test status done");
    @(posedge clock);
    stopKey <= 1'b1;
    localKey <= 1'b1;
    repeat (2) @(posedge clock);
    localKey <= 1'b0;
    settle(12);
    rd(rcio_pkg::ADDR_KEY_STAT, 8'h02);
    $display("test keys done");
    rd(rcio_pkg::ADDR_TUNE_CNT, 8'h00);
    step(1'b1);
    chk({23'h000000, irqHigh}, 24'h000000);
    step(1'b1);
    step(1'b1);
    settle(12);
    chk({23'h000000, irqHigh}, 24'h000001);
    rd(rcio_pkg::ADDR_TUNE_CNT, 8'h03);
    chk({23'h000000, irqHigh}, 24'h000000);
    step(1'b0);
    settle(30);
    chk({23'h000000, irqHigh}, 24'h000001);
    rd(rcio_pkg::ADDR_TUNE_CNT, 8'h02);
    $display("test tuning done");
    wr(rcio_pkg::ADDR_MODE, 8'h01);
    settle(1);
    chk({22'h000000, sw.directIn, sw.meterSimIn}, 24'h000001);
    wr(rcio_pkg::ADDR_MODE, 8'h02);
    settle(1);
    chk({22'h000000, sw.directIn, sw.meterSimIn}, 24'h000001);
    wr(rcio_pkg::ADDR_MODE, 8'h08);
    settle(1);
    chk({9'h000, sw}, 24'h0055c4);
    wr(rcio_pkg::ADDR_MODE, 8'h80);
    wr(8'h29, 8'h03);
    settle(1);
    chk({22'h000000, sw.posPeak, sw.negPeak}, 24'h000002);
    wr(8'h29, 8'h06);
    settle(1);
    chk({20'h00000, sw.posPeak, sw.negPeak, sw.dischargeA, sw.dischargeB}, 24'h000007);
    $display("test switches done");
    wr(rcio_pkg::ADDR_ADC_CTRL, 8'h05);
    settle(1);
    chk({23'h000000, adcSampleHold}, 24'h000001);
    for (n = 0; n < 450 && adcStartStop !== 1'b1; n++) settle(1);
    chk({23'h000000, adcStartStop}, 24'h000001);
    rd(rcio_pkg::ADDR_ADC_DATA, 8'ha5);
    rd(rcio_pkg::ADDR_ADC_DATA + 8'h01, 8'h82);
    wr(rcio_pkg::ADDR_ADC_CTRL, 8'h02);
    for (n = 0; n < 450 && adcStartStop !== 1'b0; n++) settle(1);
    chk({23'h000000, adcStartStop}, 24'h000000);
    $display("test converter done");
    @(posedge clock);
    centreInWindow <= 1'b1;
    settle(6);
    chk({23'h000000, centreStatus}, 24'h000000);
    rd(rcio_pkg::ADDR_ANA_STAT, 8'h00);
    @(posedge clock);
    centreInWindow <= 1'b0;
    calReached <= 1'b1;
    settle(6);
    chk({23'h000000, centreStatus}, 24'h000001);
    rd(rcio_pkg::ADDR_ANA_STAT, 8'h03);
    $display("test centre done");
    summarize();
  end
endmodule
bind rcio_receiver_io rcio_receiver_io_monitor i_rcio_receiver_io_monitor (
  .clock(clock), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
  .rdStrobe(rdStrobe), .rdData(rdData), .mixerOverload(mixerOverload),
  .centreInWindow(centreInWindow), .restart_interrupt_level_low(restart_interrupt_level_low),
  .restart_interrupt_level_high(restart_interrupt_level_high), .recXCode(recXCode),
  .recYCode(recYCode), .adcClock(adcClock), .adcStartStop(adcStartStop),
  .centreStatus(centreStatus), .switchEnable(switchEnable));
